/* rtl/ccr_chopper_regs.v */
`include "ccr_defs.vh"

// Functional notes
// (R1) Driver registers occupy addresses 0x6C to 0x7F.
// (R2) Chopper bit 31 set disables low-side short protection.
// (R3) Chopper bit 30 set disables short-to-ground protection.
// (R4) Bit 29 set steps on both step input edges.
// (R5) Software must not combine double-edge stepping with step filtering.
// (R6) Bit 28 set (default) interpolates resolution to 256 microsteps.
// (R7) Resolution field 27:24: code 0 is 256, codes 1-8 halve down to full step.
// (R8) Resolution field resets to 32 microsteps in serial mode.
// (R9) Reduced resolution uses table positions giving a symmetrical wave; the code steps from the current position without aligning it.
// (R10) Each step advances position by two to the resolution code.
// (R11) Blank-time field 16:15 selects 16, 24, 32 or 40 clocks.
// (R12) Blank-time resets to code 1; software should use code 0 or 1.
// (R13) Chopper bit 0 enables the driver and resets to one.
// (R14) Read-only driver status at 0x6F shows flags and current level.
// (R15) Read/write PWM configuration register at 0x70.
// (R16) Read-only scale register at 0x71; 255 means maximum voltage.
// (R17) Register 0x72 bits 7:0 return the automatic PWM offset.
// (R18) Register 0x72 bits 23:16 return the automatic PWM gradient.
// (R19) Software may copy the automatic results into the manual fields.
// (R20) Reserved chopper bits are written zero and ignored by the device.
module ccr_chopper_regs #(
  parameter PWMCFG_WIDTH = 22,
  parameter AMP_WIDTH = 17
) (
  input wire CLOCK,
  input wire RESET_N,
  input wire CLK_EN,
  input wire [6:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [31:0] REG_WDATA,
  output reg [31:0] REG_RDATA,
  output reg REG_ACK,
  output wire REG_ERR,
  input wire [31:0] DRIVER_STATUS,
  input wire [8:0] PWM_SCALE_SUM,
  input wire [7:0] PWM_SCALE_AUTO,
  input wire [7:0] AUTO_PWM_OFFSET,
  input wire [7:0] AUTO_PWM_GRADIENT,
  input wire STEP_EDGE,
  input wire STEP_DIR,
  output wire LOW_SIDE_SHORT_PROTECT_OFF,
  output wire GROUND_SHORT_PROTECT_OFF,
  output wire DRIVER_ENABLE,
  output wire INTERPOLATE,
  output wire [3:0] RESOLUTION,
  output wire [5:0] BLANK_CLOCKS,
  output wire [31:0] PWM_CONFIGURATION,
  output reg [9:0] MICROSTEP_POS,
  output wire STEP_TAKEN
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function in_range;
    input [6:0] a;
    begin
      in_range = (a >= `CCR_ADDR_LO) && (a <= `CCR_ADDR_HI); // R1
    end
  endfunction

  // Microsteps per step pulse; codes above 8 treated as full step
  function [9:0] step_increment;
    input [3:0] code;
    begin
      if (code > 4'h8) begin
        step_increment = 10'h100;
      end else begin
        step_increment = 10'h001 << code; // R10
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers

  reg [31:0] chop_ff;
  reg [PWMCFG_WIDTH-1:0] pwmcfg_ff;
  reg step_in_ff;
  reg [9:0] nxt_pos;
  wire [31:0] pwmcfg_reset = `CCR_PWMCFG_RESET;

  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      chop_ff <= `CCR_CHOP_RESET; // R8 R12 R13 R6
      pwmcfg_ff <= pwmcfg_reset[PWMCFG_WIDTH-1:0];
    end else if (CLK_EN && REG_WR) begin
      if (REG_ADDR == `CCR_ADDR_CHOP) begin
        chop_ff <= REG_WDATA & `CCR_CHOP_MASK; // R20
      end
      if (REG_ADDR == `CCR_ADDR_PWMCFG) begin
        pwmcfg_ff <= REG_WDATA[PWMCFG_WIDTH-1:0]; // R15
      end
    end
  end

  assign LOW_SIDE_SHORT_PROTECT_OFF = chop_ff[`CCR_BIT_LS_OFF]; // R2
  assign GROUND_SHORT_PROTECT_OFF = chop_ff[`CCR_BIT_GND_OFF]; // R3
  assign INTERPOLATE = chop_ff[`CCR_BIT_INTPOL]; // R6
  assign RESOLUTION = chop_ff[`CCR_MRES_HI:`CCR_MRES_LO]; // R7
  assign DRIVER_ENABLE = chop_ff[`CCR_BIT_ENABLE]; // R13
  assign PWM_CONFIGURATION = {{(32-PWMCFG_WIDTH){1'b0}}, pwmcfg_ff};

  reg [5:0] blank_sel;
  always @* begin
    case (chop_ff[`CCR_TBL_HI:`CCR_TBL_LO]) // R11
      2'h0: blank_sel = `CCR_TBL_CLK0;
      2'h1: blank_sel = `CCR_TBL_CLK1;
      2'h2: blank_sel = `CCR_TBL_CLK2;
      2'h3: blank_sel = `CCR_TBL_CLK3;
      default: blank_sel = `CCR_TBL_CLK1;
    endcase
  end
  assign BLANK_CLOCKS = blank_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Step handling: position moves by the step increment from wherever it stands,
  // with no alignment, so reduced resolutions keep any offset left by finer steps.

  wire step_rise = STEP_EDGE & ~step_in_ff;
  wire step_fall = ~STEP_EDGE & step_in_ff;
  assign STEP_TAKEN = DRIVER_ENABLE &
    (step_rise | (chop_ff[`CCR_BIT_DEDGE] & step_fall)); // R4

  always @* begin
    nxt_pos = MICROSTEP_POS;
    if (STEP_TAKEN) begin
      if (STEP_DIR) begin
        nxt_pos = MICROSTEP_POS - step_increment(RESOLUTION); // R10
      end else begin
        nxt_pos = MICROSTEP_POS + step_increment(RESOLUTION); // R10
      end
    end
  end

  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      step_in_ff <= 1'b0;
      MICROSTEP_POS <= 10'h000;
    end else if (CLK_EN) begin
      step_in_ff <= STEP_EDGE;
      MICROSTEP_POS <= nxt_pos; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: one-cycle registered answer

  reg [31:0] rd_mux;
  always @* begin
    case (REG_ADDR)
      `CCR_ADDR_CHOP: rd_mux = chop_ff;
      `CCR_ADDR_DRVST: rd_mux = DRIVER_STATUS; // R14
      `CCR_ADDR_PWMCFG: rd_mux = PWM_CONFIGURATION;
      `CCR_ADDR_PWMAMP: rd_mux = {15'h0, PWM_SCALE_SUM[0], PWM_SCALE_AUTO,
        PWM_SCALE_SUM[8:1]}; // R16
      `CCR_ADDR_PWMAUTO: rd_mux = {8'h00, AUTO_PWM_GRADIENT, 8'h00,
        AUTO_PWM_OFFSET}; // R17 R18
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Unmapped addresses inside the set read zero, outside flag an error
  assign REG_ERR = (REG_RD | REG_WR) & ~in_range(REG_ADDR); // R1

  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= 32'h00000000;
      REG_ACK <= 1'b0;
    end else if (CLK_EN) begin
      REG_ACK <= REG_RD | REG_WR;
      if (REG_RD) begin
        REG_RDATA <= rd_mux;
      end
    end
  end

endmodule // ccr_chopper_regs

/* rtl/ccr_defs.vh */
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// Register offsets in the driver register set
`define CCR_ADDR_LO 7'h6c
`define CCR_ADDR_HI 7'h7f
`define CCR_ADDR_CHOP 7'h6c
`define CCR_ADDR_DRVST 7'h6f
`define CCR_ADDR_PWMCFG 7'h70
`define CCR_ADDR_PWMAMP 7'h71
`define CCR_ADDR_PWMAUTO 7'h72

// Reset values
`define CCR_CHOP_RESET 32'h13008001
`define CCR_PWMCFG_RESET 32'hc40d1024

// Chopper configuration field positions
`define CCR_BIT_LS_OFF 31
`define CCR_BIT_GND_OFF 30
`define CCR_BIT_DEDGE 29
`define CCR_BIT_INTPOL 28
`define CCR_MRES_HI 27
`define CCR_MRES_LO 24
`define CCR_TBL_HI 16
`define CCR_TBL_LO 15
`define CCR_BIT_ENABLE 0
// Writable bits of the chopper word; reserved bits stay zero
`define CCR_CHOP_MASK 32'hff018001

// Result field positions
`define CCR_OFS_HI 7
`define CCR_OFS_LO 0
`define CCR_GRAD_HI 23
`define CCR_GRAD_LO 16

// Blank time in clocks per code
`define CCR_TBL_CLK0 6'h10
`define CCR_TBL_CLK1 6'h18
`define CCR_TBL_CLK2 6'h20
`define CCR_TBL_CLK3 6'h28

`endif

/* testbench/ccr_chk.sv */
module ccr_chk (
  input wire CLOCK,
  input wire RESET_N,
  input wire CLK_EN,
  input wire [6:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [31:0] REG_WDATA,
  input wire REG_ACK,
  input wire REG_ERR,
  input wire DRIVER_ENABLE,
  input wire [3:0] RESOLUTION,
  input wire [5:0] BLANK_CLOCKS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  wire rq = CLK_EN && (REG_WR || REG_RD);
  wire wc = rq && REG_WR && REG_ADDR == 7'h6c;
  property p_ack; rq && REG_ADDR > 7'h6b |=> REG_ACK; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_idle; !rq |=> !REG_ACK; endproperty
  a_idle: assert property (p_idle) else $error("stray ack");
  property p_err; rq |-> REG_ERR == (REG_ADDR < 7'h6c); endproperty
  a_err: assert property (p_err) else $error("range flag");
  property p_res; wc |=> RESOLUTION == $past(REG_WDATA[27:24]); endproperty
  a_res: assert property (p_res) else $error("resolution");
  property p_tbl; wc |=> BLANK_CLOCKS == 6'h10 + 6'h08 * $past(REG_WDATA[16:15]); endproperty
  a_tbl: assert property (p_tbl) else $error("blank");
  property p_en; wc |=> DRIVER_ENABLE == $past(REG_WDATA[0]); endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_rst; $rose(RESET_N) |-> RESOLUTION == 4'h3 && BLANK_CLOCKS == 6'h18; endproperty
  a_rst: assert property (p_rst) else $error("defaults");
  property p_ro; rq && REG_WR && !wc |=> $stable(RESOLUTION); endproperty
  a_ro: assert property (p_ro) else $error("ro write");
  c_wr: cover property (wc);
  c_err: cover property (rq && REG_ERR);
  c_ro: cover property (rq && REG_WR && !wc);
endmodule // ccr_chk
////////////////////////////////
bind ccr_chopper_regs ccr_chk ccr_chk_i (.*);

/* testbench/ccr_host.sv */
module ccr_host (
  input wire CLOCK,
  output logic [6:0] REG_ADDR,
  output logic REG_WR,
  output logic REG_RD,
  output logic [31:0] REG_WDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = '0;
  end
  // Strobe lasts one edge only, holding it longer would repeat the access
  task automatic acc(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(negedge CLOCK);
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, d};
    @(negedge CLOCK);
    {REG_WR, REG_RD, REG_WDATA} = {2'b00, ~d};
  endtask
endmodule // ccr_host

/* testbench/chopper_control_registers_bench.sv */
module chopper_control_registers_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 0, RESET_N = 0, CLK_EN = 1, STEP_EDGE = 0, STEP_DIR = 0, rd_q = 0;
  logic REG_WR, REG_RD, REG_ACK, REG_ERR, STEP_TAKEN, DRIVER_ENABLE, INTERPOLATE;
  logic LOW_SIDE_SHORT_PROTECT_OFF, GROUND_SHORT_PROTECT_OFF;
  logic [6:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, DRIVER_STATUS, PWM_CONFIGURATION, d;
  logic [8:0] PWM_SCALE_SUM;
  logic [7:0] PWM_SCALE_AUTO, AUTO_PWM_OFFSET, AUTO_PWM_GRADIENT;
  logic [3:0] RESOLUTION;
  logic [5:0] BLANK_CLOCKS;
  logic [9:0] MICROSTEP_POS, pos = 0;
  logic [31:0] exp_q[$];
  int seed = 32'hc9d82823;
  int error_cnt = 0, n_compared = 0;
  ccr_chopper_regs ccr_chopper_regs_i (.*);
  ccr_host ccr_host_i (.*);
  ////////////////////////////////
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ccr_host_i.acc(1'b0, a, 32'h0);
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    rd_q <= REG_RD;
    if (REG_ACK && rd_q) chk(REG_RDATA, exp_q.pop_front(), "read data");
  end
  initial begin
    forever #2.5 CLOCK = ~CLOCK;
  end
  initial begin
    #20us;
    error_cnt++;
    complete_run();
  end
  initial begin
    DRIVER_STATUS = $random(seed);
    {PWM_SCALE_SUM, PWM_SCALE_AUTO, AUTO_PWM_OFFSET, AUTO_PWM_GRADIENT} =
      33'({$random(seed), $random(seed)});
    repeat (5) @(negedge CLOCK);
    RESET_N = 1;
    rd(7'h6c, 32'h13008001);
    rd(7'h70, 32'h000d1024);
    for (int i = 0; i < 9; i++) begin
      ccr_host_i.acc(1'b1, 7'h6c, {4'h3, 4'(i), 7'h0, 2'(i), 15'h1});
      repeat (2) begin
        @(negedge CLOCK);
        STEP_EDGE = ~STEP_EDGE;
      end
      @(negedge CLOCK);
      pos = pos + (10'h2 << i);
      chk(MICROSTEP_POS, pos, "position");
      chk(BLANK_CLOCKS, 6'h10 + 6'h08 * 2'(i), "blank clocks");
    end
    // Single edge, decrement: only the rising edge may move the position
    ccr_host_i.acc(1'b1, 7'h6c, 32'h10000001);
    STEP_DIR = 1;
    @(negedge CLOCK);
    STEP_EDGE = ~STEP_EDGE;
    #1 chk(STEP_TAKEN, 1'b1, "step taken rise");
    @(negedge CLOCK);
    STEP_EDGE = ~STEP_EDGE;
    #1 chk(STEP_TAKEN, 1'b0, "step taken fall");
    @(negedge CLOCK);
    pos = pos - 10'h1;
    chk(MICROSTEP_POS, pos, "position down");
    // A write while the clock enable is low must not land
    CLK_EN = 0;
    ccr_host_i.acc(1'b1, 7'h6c, 32'h0);
    CLK_EN = 1;
    chk(DRIVER_ENABLE, 1'b1, "enable frozen");
    d = $random(seed);
    ccr_host_i.acc(1'b1, 7'h6c, d);
    chk(LOW_SIDE_SHORT_PROTECT_OFF, d[31], "low side off");
    chk(GROUND_SHORT_PROTECT_OFF, d[30], "ground off");
    chk(INTERPOLATE, d[28], "interpolate");
    ccr_host_i.acc(1'b1, 7'h10, ~d);
    ccr_host_i.acc(1'b1, 7'h6f, ~d);
    rd(7'h6c, d & 32'hff018001);
    ccr_host_i.acc(1'b1, 7'h70, d);
    rd(7'h70, {10'h0, d[21:0]});
    rd(7'h6f, DRIVER_STATUS);
    rd(7'h71, {15'h0, PWM_SCALE_SUM[0], PWM_SCALE_AUTO, PWM_SCALE_SUM[8:1]});
    rd(7'h72, {8'h0, AUTO_PWM_GRADIENT, 8'h0, AUTO_PWM_OFFSET});
    rd(7'h7f, 32'h0);
    repeat (3) @(negedge CLOCK);
    chk(exp_q.size(), 0, "pending reads");
    complete_run();
  end
endmodule // chopper_control_registers_bench
